// *** ssdr_fifo.v ***
`timescale 1ns/1ps
module ssdr_fifo #(
  parameter W = 28,
  parameter DEPTH = 32,
  parameter AW = $clog2(DEPTH)
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_in_valid,
  output reg o_in_ready,
  input wire [W-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  localparam [AW:0] DEPTH_C = DEPTH;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  reg [AW:0] count_d;
  wire push;
  wire pop;

  assign push = i_ce & i_in_valid & o_in_ready;
  assign pop = i_ce & i_out_ready & o_out_valid;
  assign o_out_data = mem[rd_ptr_q];

  always @* begin
    count_d = count_q;
    if (push & ~pop)
      count_d = count_q + 1'b1;
    else if (pop & ~push)
      count_d = count_q - 1'b1;
  end

  always @(posedge i_clk) begin
    if (push)
      mem[wr_ptr_q] <= i_in_data;
  end

  // full and empty kept as flops so the ready port is registered
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else if (i_ce) begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_d;
      o_in_ready <= (count_d != DEPTH_C);
      o_out_valid <= (count_d != {(AW+1){1'b0}});
    end
  end
endmodule

// *** ssdr_host_model.sv ***
`timescale 1ns/1ps
module ssdr_host_model (
  output logic o_chip_select_n,
  output logic o_sclk,
  output logic o_din,
  input wire i_dout
);
  // ****
  // mode 0 master, 160 ns link clock
  // ****
  initial begin
    o_chip_select_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  // idle line wanders so a deselected device cannot rely on it
  always #160 if (o_chip_select_n) o_din = ~o_din;
  task automatic xfer(input logic [7:0] c, input logic [23:0] w, input int n,
    output logic [23:0] r);
    logic [31:0] sh;
    sh = {c, w};
    r = 24'h0;
    o_chip_select_n = 1'b0;
    #80;
    for (int i = 0; i < 8 + n; i++) begin
      o_din = sh[31-i];
      #80 o_sclk = 1'b1;
      if (i >= 8)
        r = {r[22:0], i_dout};
      #80 o_sclk = 1'b0;
    end
    #80 o_chip_select_n = 1'b1;
    #160;
  endtask
endmodule

// *** ssdr_regs.vh ***
`ifndef SSDR_REGS_VH
`define SSDR_REGS_VH

// ****************************************
// command byte layout
// ****************************************
`define SSDR_CMD_BITS 8
`define SSDR_CMD_START_BIT 7
`define SSDR_CMD_REG_BIT 6
`define SSDR_CMD_RW_BIT 0
`define SSDR_ADDR_MSB 5
`define SSDR_ADDR_LSB 1

// ****************************************
// register addresses and sizes
// ****************************************
`define SSDR_ADDR_STAT 5'h00
`define SSDR_ADDR_DATA 5'h06
`define SSDR_BYTES_DATA 3'h3
`define SSDR_BYTES_STAT 3'h2
`define SSDR_BYTES_OTHER 3'h1

// ****************************************
// status field positions
// ****************************************
`define SSDR_STAT_DONE_LSB 0
`define SSDR_MODULATOR_ACTIVE_BIT 8

// ****************************************
// timing counts
// ****************************************
`define SSDR_RD_DONE_BITS 23
`define SSDR_PRE_CYCLES 4
`define SSDR_WARMUP_RESULTS 4
`define SSDR_FIFO_DEPTH 32

`endif

// *** ssdr_spi_ready.v ***
`timescale 1ns/1ps
`include "ssdr_regs.vh"

// Operation
// - chip select is active low; traffic is served only while it is low
// - chip select rising returns the serial port to idle, dropping partial work
// - input line sampled on each serial clock rise while selected
// - output bit changes on each serial clock fall
// - deselected: clock and input ignored, output released
// - output driven for the whole time chip select is low
// - registers reachable are 8 to 24 bits wide
// - ready low means result readable, high means conversion pending
// - completed data read drives ready high
// - ready goes high four master cycles before the data register loads
// - after a read, ready falls once per output sample
// - unread result: ready high for four cycles, then low again
// - continuous mode: ready stays high for four results, falls on fifth
// - sequencer 2/3 with suppression clear: per-channel single-channel behaviour
// - per-channel signalling gives one falling edge per enabled channel
// - suppression set: only the last channel drops ready
// - six channel done flags set on completion in sequencer 2/3
// - modulator active flag high while converting
// - command byte starts with 1; next bit picks conversion or register access
// - writes commit per byte, MSB first, every eighth clock from the sixteenth
// - data read of 23 bits or more completes; shorter leaves ready low
module ssdr_spi_ready #(
  parameter DATA_W = 24,
  parameter CHAN_W = 3,
  parameter NCHAN = 6,
  parameter FIFO_DEPTH = `SSDR_FIFO_DEPTH
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_chip_select_n,
  input wire i_sclk,
  input wire i_din,
  output reg o_dout,
  output reg o_dout_oe,
  output reg o_result_ready_n,
  input wire i_res_valid,
  output wire o_res_ready,
  input wire [DATA_W-1:0] i_res_data,
  input wire [CHAN_W-1:0] i_res_chan,
  input wire i_res_last,
  input wire i_continuous,
  input wire [1:0] i_sequencer_config,
  input wire i_ready_last_channel_only,
  input wire i_conv_start,
  input wire i_modulator_busy,
  input wire [NCHAN-1:0] i_done_clear,
  output reg [NCHAN-1:0] o_channel_done_flags,
  output reg o_modulator_active,
  output reg o_conv_cmd_valid,
  output reg [5:0] o_conv_cmd,
  output reg o_wr_valid,
  output reg [4:0] o_wr_addr,
  output reg [1:0] o_wr_byte,
  output reg [7:0] o_wr_data,
  output reg [4:0] o_rd_addr,
  input wire [23:0] i_reg_rdata
);
  localparam FW = DATA_W + CHAN_W + 1;
  localparam [1:0] RS_IDLE = 2'b00;
  localparam [1:0] RS_PRE = 2'b01;
  localparam [2:0] PRE_LAST = `SSDR_PRE_CYCLES - 1;
  localparam [2:0] WARM_N = `SSDR_WARMUP_RESULTS;
  localparam [5:0] CMD_END = `SSDR_CMD_BITS;
  localparam [5:0] RD_DONE_CNT = `SSDR_CMD_BITS + `SSDR_RD_DONE_BITS;

  // ****************************************
  // helpers
  // ****************************************
  function [2:0] reg_bytes;
    input [4:0] addr;
    begin
      if (addr == `SSDR_ADDR_DATA)
        reg_bytes = `SSDR_BYTES_DATA;
      else if (addr == `SSDR_ADDR_STAT)
        reg_bytes = `SSDR_BYTES_STAT;
      else
        reg_bytes = `SSDR_BYTES_OTHER;
    end
  endfunction

  // every register leaves MSB first, so the word is left aligned
  function [23:0] rd_word;
    input [4:0] addr;
    input [23:0] data;
    input [15:0] stat;
    input [23:0] ext;
    begin
      if (addr == `SSDR_ADDR_DATA)
        rd_word = data;
      else if (addr == `SSDR_ADDR_STAT)
        rd_word = {stat, 8'h00};
      else
        rd_word = ext;
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire sclk_s;
  wire csn_s;
  wire din_s;

  ssdr_sync #(.W(3), .RST_VAL(3'b010)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_sclk, i_chip_select_n, i_din}),
    .o_sync({sclk_s, csn_s, din_s})
  );

  reg sclk_d_q;
  wire sclk_rise;
  wire sclk_fall;

  assign sclk_rise = sclk_s & ~sclk_d_q & ~csn_s;
  assign sclk_fall = ~sclk_s & sclk_d_q & ~csn_s;

  // ****************************************
  // serial port
  // ****************************************
  reg [5:0] bit_cnt_q;
  reg [7:0] rx_q;
  reg [23:0] tx_q;
  reg is_reg_q;
  reg is_read_q;
  reg data_rd_q;
  reg rd_done_q;
  reg [4:0] addr_q;
  reg [DATA_W-1:0] data_q;
  wire [7:0] rx_d;
  wire [5:0] cnt_d;
  wire [2:0] wr_idx;
  wire [15:0] stat_word;
  wire [23:0] rd_now;

  assign rx_d = {rx_q[6:0], din_s};
  assign cnt_d = (bit_cnt_q == 6'h3f) ? bit_cnt_q : bit_cnt_q + 6'h01;
  assign wr_idx = cnt_d[5:3] - 3'h2;
  assign stat_word = {7'h00, o_modulator_active, 2'h0, o_channel_done_flags};
  assign rd_now = rd_word(addr_q, data_q, stat_word, i_reg_rdata);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_d_q <= 1'b0;
      bit_cnt_q <= 6'h00;
      rx_q <= 8'h00;
      tx_q <= 24'h00_0000;
      is_reg_q <= 1'b0;
      is_read_q <= 1'b0;
      data_rd_q <= 1'b0;
      rd_done_q <= 1'b0;
      addr_q <= 5'h00;
      o_dout <= 1'b0;
      o_dout_oe <= 1'b0;
      o_conv_cmd_valid <= 1'b0;
      o_conv_cmd <= 6'h00;
      o_wr_valid <= 1'b0;
      o_wr_addr <= 5'h00;
      o_wr_byte <= 2'h0;
      o_wr_data <= 8'h00;
      o_rd_addr <= 5'h00;
    end else if (i_ce) begin
      sclk_d_q <= sclk_s;
      o_conv_cmd_valid <= 1'b0;
      o_wr_valid <= 1'b0;
      rd_done_q <= 1'b0;
      o_dout_oe <= ~csn_s;
      if (csn_s) begin
        // deselected or just released: drop any half-done transfer
        bit_cnt_q <= 6'h00;
        is_reg_q <= 1'b0;
        is_read_q <= 1'b0;
        data_rd_q <= 1'b0;
        o_dout <= 1'b0;
      end else if (sclk_rise) begin
        bit_cnt_q <= cnt_d;
        rx_q <= rx_d;
        if (cnt_d == CMD_END && rx_d[`SSDR_CMD_START_BIT]) begin
          if (!rx_d[`SSDR_CMD_REG_BIT]) begin
            o_conv_cmd_valid <= 1'b1;
            o_conv_cmd <= rx_d[5:0];
          end else begin
            is_reg_q <= 1'b1;
            is_read_q <= rx_d[`SSDR_CMD_RW_BIT];
            addr_q <= rx_d[`SSDR_ADDR_MSB:`SSDR_ADDR_LSB];
            o_rd_addr <= rx_d[`SSDR_ADDR_MSB:`SSDR_ADDR_LSB];
            data_rd_q <= rx_d[`SSDR_CMD_RW_BIT] &
                         (rx_d[`SSDR_ADDR_MSB:`SSDR_ADDR_LSB] == `SSDR_ADDR_DATA);
          end
        end
        // short writes never reach the sixteenth clock and commit nothing
        if (is_reg_q && !is_read_q && cnt_d[2:0] == 3'h0 && cnt_d > CMD_END
            && wr_idx < reg_bytes(addr_q) && bit_cnt_q != 6'h3f) begin
          o_wr_valid <= 1'b1;
          o_wr_addr <= addr_q;
          o_wr_byte <= wr_idx[1:0];
          o_wr_data <= rx_d;
        end
        if (data_rd_q && cnt_d == RD_DONE_CNT && bit_cnt_q != 6'h3f)
          rd_done_q <= 1'b1;
      end else if (sclk_fall && is_read_q) begin
        // read stays active until deselect; past the word zeros go out
        if (bit_cnt_q == CMD_END) begin
          o_dout <= rd_now[23];
          tx_q <= {rd_now[22:0], 1'b0};
        end else begin
          o_dout <= tx_q[23];
          tx_q <= {tx_q[22:0], 1'b0};
        end
      end
    end
  end

  // ****************************************
  // result buffer
  // ****************************************
  wire fifo_valid;
  wire [FW-1:0] fifo_data;
  wire pop;
  reg [1:0] rs_q;
  reg [2:0] pre_cnt_q;
  reg [2:0] warm_q;

  // draining waits while a data read is in flight, so results back up here
  assign pop = (rs_q == RS_PRE) && (pre_cnt_q == PRE_LAST);

  ssdr_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_in_valid(i_res_valid),
    .o_in_ready(o_res_ready),
    .i_in_data({i_res_last, i_res_chan, i_res_data}),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_data)
  );

  // ****************************************
  // data ready sequencing
  // ****************************************
  wire seq_multi;
  wire f_last;
  wire [CHAN_W-1:0] f_chan;
  wire warm_hide;
  wire seq_hide;
  reg [NCHAN-1:0] done_set;

  assign seq_multi = (i_sequencer_config == 2'h2) || (i_sequencer_config == 2'h3);
  assign f_last = fifo_data[FW-1];
  assign f_chan = fifo_data[FW-2:DATA_W];
  assign warm_hide = i_continuous && (warm_q < WARM_N);
  assign seq_hide = seq_multi && i_ready_last_channel_only && !f_last;

  always @* begin
    done_set = {NCHAN{1'b0}};
    if (pop && seq_multi)
      done_set[f_chan] = 1'b1;
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rs_q <= RS_IDLE;
      pre_cnt_q <= 3'h0;
      warm_q <= 3'h0;
      data_q <= {DATA_W{1'b0}};
      o_result_ready_n <= 1'b1;
      o_channel_done_flags <= {NCHAN{1'b0}};
      o_modulator_active <= 1'b0;
    end else if (i_ce) begin
      o_modulator_active <= i_modulator_busy;
      // a completion in the clearing cycle survives
      o_channel_done_flags <= (o_channel_done_flags & ~i_done_clear) | done_set;
      if (i_conv_start)
        warm_q <= 3'h0;
      if (rd_done_q)
        o_result_ready_n <= 1'b1;
      case (rs_q)
        RS_IDLE: begin
          if (fifo_valid && !data_rd_q) begin
            rs_q <= RS_PRE;
            pre_cnt_q <= 3'h0;
            o_result_ready_n <= 1'b1;
          end
        end
        RS_PRE: begin
          pre_cnt_q <= pre_cnt_q + 3'h1;
          if (pre_cnt_q == PRE_LAST) begin
            rs_q <= RS_IDLE;
            data_q <= fifo_data[DATA_W-1:0];
            if (i_continuous && warm_q < WARM_N && !i_conv_start)
              warm_q <= warm_q + 3'h1;
            if (!warm_hide && !seq_hide)
              o_result_ready_n <= 1'b0;
          end
        end
        default: rs_q <= RS_IDLE;
      endcase
    end
  end
endmodule

// *** ssdr_spi_ready_checker.sv ***
`timescale 1ns/1ps
module ssdr_chk #(
  parameter NCHAN = 6
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_chip_select_n,
  input wire i_sclk,
  input wire o_dout,
  input wire o_dout_oe,
  input wire o_result_ready_n,
  input wire i_modulator_busy,
  input wire o_modulator_active,
  input wire [NCHAN-1:0] i_done_clear,
  input wire [NCHAN-1:0] o_channel_done_flags,
  input wire o_conv_cmd_valid,
  input wire o_wr_valid
);
  logic sclk_q;
  logic cs_q;
  logic [3:0] age_q;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ****
  // cycles since a clock fall or select edge
  // ****
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      age_q <= 4'hf;
    end else begin
      sclk_q <= i_sclk;
      cs_q <= i_chip_select_n;
      if ((sclk_q && !i_sclk) || (cs_q != i_chip_select_n))
        age_q <= 4'h0;
      else if (age_q != 4'hf)
        age_q <= age_q + 4'h1;
    end
  end
  // ****
  // properties
  // ****
  AST_OE_OFF:
    assert property (i_chip_select_n [*4] |-> !o_dout_oe)
    else $error("output driven while deselected");
  AST_OE_ON:
    assert property (!i_chip_select_n [*4] |-> o_dout_oe)
    else $error("output released while selected");
  // sync delay is 2-3 cycles, 7 leaves margin
  AST_DOUT_FALL:
    assert property ($changed(o_dout) && o_dout_oe |-> age_q <= 4'h7)
    else $error("output bit moved away from a clock fall");
  AST_RDY_PRE:
    assert property ($fell(o_result_ready_n) |->
      $past(o_result_ready_n, 2) && $past(o_result_ready_n, 3) && $past(o_result_ready_n, 4))
    else $error("ready fell without four high cycles");
  AST_MOD_ACT:
    assert property (o_modulator_active == $past(i_modulator_busy))
    else $error("modulator flag does not follow busy");
  AST_FLAG_STICKY:
    assert property ((~$past(i_done_clear) & $past(o_channel_done_flags) &
      ~o_channel_done_flags) == '0)
    else $error("done flag lost without clear");
  AST_CONV_PULSE:
    assert property (o_conv_cmd_valid |-> o_dout_oe ##1 !o_conv_cmd_valid)
    else $error("conversion pulse malformed");
  AST_WR_PULSE:
    assert property (o_wr_valid |-> o_dout_oe ##1 !o_wr_valid)
    else $error("write pulse malformed");
endmodule

// *** ssdr_sync.v ***
`timescale 1ns/1ps
module ssdr_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// *** tb_ssdr_spi_ready.sv ***
`timescale 1ns/1ps
module tb_ssdr_spi_ready;
  logic i_clk, i_rst, cs_n, sclk, din, dout, oe, rdy_n, res_valid, res_ready, res_last;
  logic cont, sup, conv_start, mod_busy, mod_act, conv_v, wr_v;
  logic [1:0] seq, wr_byte;
  logic [2:0] res_chan;
  logic [4:0] wr_addr, rd_addr;
  logic [5:0] done_clear, flags, conv_cmd;
  logic [7:0] wr_data;
  logic [23:0] res_data, reg_rdata, rd, d;
  logic [31:0] seed;
  int failures, checked, n_wr, n_conv, lat, k;
  ssdr_spi_ready ssdr_spi_ready_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_chip_select_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe(oe),
    .o_result_ready_n(rdy_n), .i_res_valid(res_valid), .o_res_ready(res_ready),
    .i_res_data(res_data), .i_res_chan(res_chan), .i_res_last(res_last),
    .i_continuous(cont), .i_sequencer_config(seq), .i_ready_last_channel_only(sup),
    .i_conv_start(conv_start), .i_modulator_busy(mod_busy), .i_done_clear(done_clear),
    .o_channel_done_flags(flags), .o_modulator_active(mod_act), .o_conv_cmd_valid(conv_v),
    .o_conv_cmd(conv_cmd), .o_wr_valid(wr_v), .o_wr_addr(wr_addr), .o_wr_byte(wr_byte),
    .o_wr_data(wr_data), .o_rd_addr(rd_addr), .i_reg_rdata(reg_rdata));
  ssdr_host_model ssdr_host_model_inst (.o_chip_select_n(cs_n), .o_sclk(sclk),
    .o_din(din), .i_dout(dout));
  // ****
  // helpers
  // ****
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [23:0] exp_lat(input logic s, input int ch);
    return (s && ch < 2) ? 24'h63 : 24'h5;
  endfunction
  task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic host(input logic [7:0] c, input logic [23:0] w, input int n);
    ssdr_host_model_inst.xfer(c, w, n, rd);
  endtask
  // latency in cycles to the ready fall, 99 when none follows
  task automatic push(input logic [23:0] v, input int ch, input logic last, output int l);
    logic prev;
    l = 99;
    res_data = v;
    res_chan = 3'(ch);
    res_last = last;
    res_valid = 1'b1;
    tick();
    res_valid = 1'b0;
    prev = rdy_n;
    for (int j = 1; j <= 40; j++) begin
      tick();
      if (prev && !rdy_n && l == 99)
        l = j;
      prev = rdy_n;
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (wr_v)
      n_wr++;
    if (conv_v)
      n_conv++;
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    failures++;
    stop_test();
  end
  // ****
  // scenarios
  // ****
  initial begin
    {i_rst, res_valid, res_last, cont, sup, conv_start, mod_busy} = 7'h40;
    seq = 2'h0;
    res_chan = 3'h0;
    done_clear = 6'h0;
    res_data = 24'h0;
    reg_rdata = 24'h0;
    seed = 32'hde51_86f0;
    repeat (20) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (4) tick();
    check("ready idle", rdy_n, 24'h1);
    check("output enable", oe, 24'h0);
    d = seed[23:0];
    push(d, 0, 1'b0, lat);
    check("latency", 24'(lat), 24'h5);
    host(8'hCD, 24'h0, 24);
    check("data", rd, d);
    check("ready after read", rdy_n, 24'h1);
    seed = lfsr(seed);
    d = seed[23:0];
    push(d, 1, 1'b0, lat);
    check("latency after read", 24'(lat), 24'h5);
    host(8'hCD, 24'h0, 16);
    check("short read", rd, {8'h0, d[23:8]});
    check("ready kept", rdy_n, 24'h0);
    push(24'(lfsr(seed)), 2, 1'b0, lat);
    check("unread latency", 24'(lat), 24'h5);
    cont = 1'b1;
    conv_start = 1'b1;
    tick();
    conv_start = 1'b0;
    for (k = 0; k < 5; k++) begin
      push(24'(k), 0, 1'b0, lat);
      check("warm-up", 24'(lat), k < 4 ? 24'h63 : 24'h5);
    end
    cont = 1'b0;
    for (int m = 0; m < 4; m++) begin
      seq = 2'h2 + 2'(m / 2);
      sup = m[0];
      for (k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        push(seed[23:0], k, k == 2, lat);
        check("sweep latency", 24'(lat), exp_lat(sup, k));
      end
      check("done flags", flags, 24'h7);
      done_clear = 6'h3f;
      tick();
      done_clear = 6'h0;
    end
    seq = 2'h0;
    sup = 1'b0;
    seed = lfsr(seed);
    host(8'hC6, seed[23:0], 16);
    check("write count", 24'(n_wr), 24'h1);
    check("write data", wr_data, seed[23:16]);
    check("write addr", wr_addr, 24'h3);
    check("write byte", wr_byte, 24'h0);
    // fifteen clocks in all: one short of the first byte
    host(8'hC6, seed[23:0], 7);
    check("partial write", 24'(n_wr), 24'h1);
    host(8'h80 | {2'h0, seed[5:0]}, 24'h0, 0);
    check("conv cmd", conv_cmd, seed[5:0]);
    host(8'h4D, seed[23:0], 16);
    check("cmd count", 24'(n_conv + n_wr), 24'h2);
    reg_rdata = seed[31:8];
    host(8'hC7, 24'h0, 8);
    check("reg read", rd, reg_rdata[23:16]);
    check("read addr", rd_addr, 24'h3);
    mod_busy = 1'b1;
    host(8'hC1, 24'h0, 16);
    check("status", {rd[8], rd[5:0]}, 24'h40);
    k = 0;
    fork
      host(8'hCD, 24'h0, 24);
      begin
        repeat (400) tick();
        for (int j = 0; j < 40; j++) begin
          seed = lfsr(seed);
          res_data = seed[23:0];
          res_valid = res_ready;
          tick();
          if (res_valid)
            k++;
          if (res_valid)
            d = res_data;
        end
        res_valid = 1'b0;
      end
    join
    check("fifo words", 24'(k), 24'h20);
    repeat (400) tick();
    host(8'hCD, 24'h0, 24);
    check("drained", rd, d);
    stop_test();
  end
endmodule

bind ssdr_spi_ready ssdr_chk #(.NCHAN(NCHAN)) ssdr_chk_inst (.i_clk(i_clk), .i_rst(i_rst),
  .i_chip_select_n(i_chip_select_n), .i_sclk(i_sclk), .o_dout(o_dout),
  .o_dout_oe(o_dout_oe), .o_result_ready_n(o_result_ready_n),
  .i_modulator_busy(i_modulator_busy), .o_modulator_active(o_modulator_active),
  .i_done_clear(i_done_clear), .o_channel_done_flags(o_channel_done_flags),
  .o_conv_cmd_valid(o_conv_cmd_valid), .o_wr_valid(o_wr_valid));
